// File: rtl/lcep_pkg.sv
// lcep_pkg: register map, field codes and reset values of the link
// configuration and edit-protection bank.
// assumes a 32-bit classic wishbone slave, byte addresses, one word each.
package lcep_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] LCEP_OFS_LINK     = 8'h00;
    localparam logic [7:0] LCEP_OFS_TIMING   = 8'h04;
    localparam logic [7:0] LCEP_OFS_MODE     = 8'h08;
    localparam logic [7:0] LCEP_OFS_PROTECT  = 8'h0c;
    localparam logic [7:0] LCEP_OFS_PARAM    = 8'h10;
    localparam logic [7:0] LCEP_OFS_REF      = 8'h14;
    localparam logic [7:0] LCEP_OFS_STATUS   = 8'h18;
    localparam logic [7:0] LCEP_OFS_SILENCE  = 8'h1c;

    // ------------------------------------------------------------------
    // link register fields
    // ------------------------------------------------------------------
    localparam int LCEP_BAUD_LSB   = 0;
    localparam int LCEP_DLEN_BIT   = 4;
    localparam int LCEP_PAR_LSB    = 8;
    localparam int LCEP_STOP_BIT   = 12;
    localparam int LCEP_PROTO_LSB  = 16;

    localparam logic [2:0] LCEP_BAUD_19200 = 3'h3;
    localparam logic [2:0] LCEP_BAUD_38400 = 3'h4;
    localparam logic [2:0] LCEP_BAUD_RST   = 3'h3;
    localparam logic       LCEP_DLEN_8     = 1'b0;
    localparam logic       LCEP_DLEN_7     = 1'b1;
    localparam logic [1:0] LCEP_PAR_NONE2  = 2'h0;
    localparam logic [1:0] LCEP_PAR_EVEN   = 2'h1;
    localparam logic [1:0] LCEP_PAR_ODD    = 2'h2;
    localparam logic [1:0] LCEP_PAR_NONE1  = 2'h3;
    localparam logic       LCEP_STOP_2     = 1'b0;
    localparam logic       LCEP_STOP_1     = 1'b1;
    localparam logic [1:0] LCEP_PROTO_RTU  = 2'h0;
    localparam logic [1:0] LCEP_PROTO_GP   = 2'h2;

    // ------------------------------------------------------------------
    // timing register fields
    // ------------------------------------------------------------------
    localparam int         LCEP_NORESP_LSB = 0;
    localparam int         LCEP_RESPIV_LSB = 8;
    localparam logic [5:0] LCEP_NORESP_MAX = 6'h3c;   // 60 s
    localparam logic [5:0] LCEP_NORESP_RST = 6'h00;
    localparam logic [6:0] LCEP_RESPIV_MAX = 7'h64;   // 1.00 s
    localparam logic [6:0] LCEP_RESPIV_RST = 7'h01;   // 0.01 s

    // time bases at the 20 MHz clock
    localparam int LCEP_TICK_10MS_NS = 10000000;
    localparam int LCEP_TICK_CYC     = LCEP_TICK_10MS_NS / 50;
    localparam int LCEP_TICKS_PER_S  = 100;

    // ------------------------------------------------------------------
    // bus-link mode and edit protection codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LCEP_BUS_NONE  = 2'h0;
    localparam logic [1:0] LCEP_BUS_FREQ  = 2'h1;
    localparam logic [1:0] LCEP_BUS_RUN   = 2'h2;
    localparam logic [1:0] LCEP_BUS_BOTH  = 2'h3;
    localparam logic [1:0] LCEP_PROT_NONE = 2'h0;
    localparam logic [1:0] LCEP_PROT_PAR  = 2'h1;
    localparam logic [1:0] LCEP_PROT_REF  = 2'h2;
    localparam logic [1:0] LCEP_PROT_ALL  = 2'h3;

    localparam logic [15:0] LCEP_PARAM_RST = 16'h0000;
    localparam logic [15:0] LCEP_REF_RST   = 16'h0000;

endpackage : lcep_pkg

// File: rtl/lcep_timer.sv
// lcep_timer: response-interval and no-response silence timer.
// assumes one 20 MHz clock, asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module lcep_timer
    import lcep_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // settings
    input  wire logic [5:0] noresp_sec,
    input  wire logic [6:0] respiv_ticks,
    // link events
    input  wire logic       req_done,
    input  wire logic       rx_activity,
    // results
    output logic            reply_ok,
    output logic            silence_evt
);

    // ----------
    // 10 ms tick prescaler
    // ----------
    logic [17:0] pre_ff;
    logic        tick;

    assign tick = (pre_ff == 18'(LCEP_TICK_CYC - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 18'h00000;
        end else if (tick) begin
            pre_ff <= 18'h00000;
        end else begin
            pre_ff <= pre_ff + 18'h00001;
        end
    end

    // ----------
    // response interval: ticks since the last completed request
    // ----------
    logic [6:0] resp_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resp_ff <= 7'h00;
        end else if (req_done) begin
            resp_ff <= 7'h00;
        end else if (tick && resp_ff != 7'h7f) begin
            resp_ff <= resp_ff + 7'h01;
        end
    end

    // a partial first tick may shorten the wait by under 10 ms
    assign reply_ok = (resp_ff >= respiv_ticks) && !req_done;

    // ----------
    // silence watchdog, counted in 10 ms ticks
    // ----------
    logic [12:0] sil_ff;
    logic [12:0] sil_lim;

    assign sil_lim = 13'(noresp_sec) * 13'(LCEP_TICKS_PER_S);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sil_ff      <= 13'h0000;
            silence_evt <= 1'b0;
        end else begin
            silence_evt <= 1'b0;
            if (rx_activity || noresp_sec == 6'h00) begin
                sil_ff <= 13'h0000;
            end else if (tick) begin
                if (sil_ff + 13'h0001 >= sil_lim) begin
                    sil_ff      <= 13'h0000;
                    silence_evt <= 1'b1;
                end else begin
                    sil_ff <= sil_ff + 13'h0001;
                end
            end
        end
    end

endmodule : lcep_timer
`default_nettype wire

// File: rtl/lcep_bank.sv
// lcep_bank: link configuration and keypad edit-protection register bank.
// assumes a classic wishbone master on the system clock, a keypad front end
// that delivers one-cycle edit strobes, and a link engine that reads the
// decoded settings.
//
// Operation
// - baud code 3 is 19200, 4 is 38400
// - length 0 is 8 bits, 1 is 7
// - parity 0 none, 1 even, 2 odd, 3 none
// - stop 0 is two bits, 1 is one, outside RTU; under RTU parity 0 gives two, else one
// - silence 0 off, 1..60 s flags error
// - reply waits at least response interval, less a partial first 10 ms tick
// - protocol 0 register RTU, 2 general drive
// - mode 1: frequency fieldbus, run selector
// - modes 3 both bus, 0 none, 2 run
// - protection 0 allows all keypad edits
// - protection 1 locks parameters, not references
// - protection 2 locks references, not parameters
// - protection 3 locks parameters and references
// - selector is set by link writes; two-key combos move it only between 0 and 1
// - link writes ignore protection
// - terminal permit gates keypad parameter edits
`timescale 1ns/100ps
`default_nettype none
module lcep_bank
    import lcep_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // wishbone slave (link-side host writes arrive here)
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // keypad
    input  wire logic        kp_param_up,
    input  wire logic        kp_param_dn,
    input  wire logic        kp_ref_up,
    input  wire logic        kp_ref_dn,
    input  wire logic        kp_combo_lock,
    input  wire logic        kp_combo_unlock,
    // digital input terminal
    input  wire logic        keypad_edit_permit_en,
    input  wire logic        keypad_edit_permit,
    // link engine
    input  wire logic        link_req_done,
    input  wire logic        link_rx_activity,
    output logic             link_reply_ok,
    output logic [31:0]      link_baud_bps,
    output logic [3:0]       link_char_bits,
    output logic             link_parity_en,
    output logic             link_parity_odd,
    output logic [1:0]       link_stop_bits,
    output logic             link_proto_rtu,
    output logic             link_noresp_err,
    // command source steering
    output logic             freq_from_fieldbus,
    output logic             run_from_fieldbus,
    // stored values
    output logic [15:0]      param_value,
    output logic [15:0]      ref_value
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic bus_req;
    logic wr_ok;
    logic hit;
    logic ack_ff;
    logic err_ff;

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;

    always_comb begin
        if (wb_adr_i[1:0] != 2'h0 || wb_adr_i > LCEP_OFS_SILENCE) begin
            hit = 1'b0;
        end else begin
            hit = 1'b1;
        end
    end

    assign wr_ok = bus_req && wb_we_i && hit;

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req && hit;
            err_ff <= bus_req && !hit;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;

    // ------------------------------------------------------------------
    // link settings
    // ------------------------------------------------------------------
    logic [2:0] baud_ff;
    logic       dlen_ff;
    logic [1:0] par_ff;
    logic       stop_ff;
    logic [1:0] proto_ff;
    logic [2:0] nxt_baud;
    logic [1:0] nxt_proto;

    // unknown codes keep the stored value
    always_comb begin
        nxt_baud = wb_dat_i[LCEP_BAUD_LSB +: 3];
        if (nxt_baud != LCEP_BAUD_19200 && nxt_baud != LCEP_BAUD_38400) begin
            nxt_baud = baud_ff;
        end
        nxt_proto = wb_dat_i[LCEP_PROTO_LSB +: 2];
        if (nxt_proto != LCEP_PROTO_RTU && nxt_proto != LCEP_PROTO_GP) begin
            nxt_proto = proto_ff;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            baud_ff  <= LCEP_BAUD_RST;
            dlen_ff  <= LCEP_DLEN_8;
            par_ff   <= LCEP_PAR_NONE2;
            stop_ff  <= LCEP_STOP_2;
            proto_ff <= LCEP_PROTO_RTU;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_LINK) begin
            if (wb_sel_i[0]) begin
                baud_ff <= nxt_baud;
                dlen_ff <= wb_dat_i[LCEP_DLEN_BIT];
            end
            if (wb_sel_i[1]) begin
                par_ff  <= wb_dat_i[LCEP_PAR_LSB +: 2];
                stop_ff <= wb_dat_i[LCEP_STOP_BIT];
            end
            if (wb_sel_i[2]) begin
                proto_ff <= nxt_proto;
            end
        end
    end

    assign link_baud_bps = (baud_ff == LCEP_BAUD_38400) ? 32'd38400
                                                        : 32'd19200;
    assign link_char_bits = (dlen_ff == LCEP_DLEN_7) ? 4'h7 : 4'h8;
    assign link_parity_en = (par_ff == LCEP_PAR_EVEN)
                         || (par_ff == LCEP_PAR_ODD);
    assign link_parity_odd = (par_ff == LCEP_PAR_ODD);
    assign link_proto_rtu = (proto_ff == LCEP_PROTO_RTU);

    // under RTU parity sets the stop bits, otherwise the stop field does
    always_comb begin
        if (proto_ff == LCEP_PROTO_RTU) begin
            link_stop_bits = (par_ff == LCEP_PAR_NONE2) ? 2'h2 : 2'h1;
        end else begin
            link_stop_bits = (stop_ff == LCEP_STOP_1) ? 2'h1 : 2'h2;
        end
    end

    // ------------------------------------------------------------------
    // timing settings
    // ------------------------------------------------------------------
    logic [5:0] noresp_ff;
    logic [6:0] respiv_ff;
    logic [5:0] nxt_noresp;
    logic [6:0] nxt_respiv;

    assign nxt_noresp = wb_dat_i[LCEP_NORESP_LSB +: 6];
    assign nxt_respiv = wb_dat_i[LCEP_RESPIV_LSB +: 7];

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            noresp_ff <= LCEP_NORESP_RST;
            respiv_ff <= LCEP_RESPIV_RST;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_TIMING) begin
            if (wb_sel_i[0] && nxt_noresp <= LCEP_NORESP_MAX) begin
                noresp_ff <= nxt_noresp;
            end
            if (wb_sel_i[1] && nxt_respiv <= LCEP_RESPIV_MAX) begin
                respiv_ff <= nxt_respiv;
            end
        end
    end

    logic silence_evt;
    logic noresp_err_ff;

    lcep_timer u_timer (
        .mclk         (mclk),
        .rst_n        (rst_n_ff),
        .noresp_sec   (noresp_ff),
        .respiv_ticks (respiv_ff),
        .req_done     (link_req_done),
        .rx_activity  (link_rx_activity),
        .reply_ok     (link_reply_ok),
        .silence_evt  (silence_evt)
    );

    // sticky error; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            noresp_err_ff <= 1'b0;
        end else if (silence_evt) begin
            noresp_err_ff <= 1'b1;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_STATUS && wb_sel_i[0]
                     && wb_dat_i[0]) begin
            noresp_err_ff <= 1'b0;
        end
    end

    assign link_noresp_err = noresp_err_ff;

    // ------------------------------------------------------------------
    // bus-link mode
    // ------------------------------------------------------------------
    logic [1:0] busmode_ff;

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            busmode_ff <= LCEP_BUS_NONE;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_MODE && wb_sel_i[0]) begin
            busmode_ff <= wb_dat_i[1:0];
        end
    end

    assign freq_from_fieldbus = (busmode_ff == LCEP_BUS_FREQ)
                             || (busmode_ff == LCEP_BUS_BOTH);
    assign run_from_fieldbus = (busmode_ff == LCEP_BUS_RUN)
                            || (busmode_ff == LCEP_BUS_BOTH);

    // ------------------------------------------------------------------
    // edit protection
    // ------------------------------------------------------------------
    logic [1:0] prot_ff;
    logic       par_lock;
    logic       ref_lock;
    logic       kp_par_ok;
    logic       kp_ref_ok;

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            prot_ff <= LCEP_PROT_NONE;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_PROTECT && wb_sel_i[0]) begin
            prot_ff <= wb_dat_i[1:0];
        end else if (kp_combo_lock && prot_ff == LCEP_PROT_NONE) begin
            prot_ff <= LCEP_PROT_PAR;
        end else if (kp_combo_unlock && prot_ff == LCEP_PROT_PAR) begin
            prot_ff <= LCEP_PROT_NONE;
        end
    end

    assign par_lock = (prot_ff == LCEP_PROT_PAR)
                   || (prot_ff == LCEP_PROT_ALL);
    assign ref_lock = (prot_ff == LCEP_PROT_REF)
                   || (prot_ff == LCEP_PROT_ALL);
    // permit terminal is a second gate, only when assigned
    assign kp_par_ok = !par_lock
                    && (!keypad_edit_permit_en || keypad_edit_permit);
    assign kp_ref_ok = !ref_lock;

    // ------------------------------------------------------------------
    // parameter and reference stores
    // ------------------------------------------------------------------
    logic [15:0] param_ff;
    logic [15:0] ref_ff;
    logic        refused_ff;
    logic        kp_par_evt;
    logic        kp_ref_evt;

    assign kp_par_evt = kp_param_up ^ kp_param_dn;
    assign kp_ref_evt = kp_ref_up ^ kp_ref_dn;

    // the link wins over a keypad step in the same cycle
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            param_ff <= LCEP_PARAM_RST;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_PARAM) begin
            if (wb_sel_i[0]) param_ff[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) param_ff[15:8] <= wb_dat_i[15:8];
        end else if (kp_par_evt && kp_par_ok) begin
            param_ff <= kp_param_up ? param_ff + 16'h0001
                                    : param_ff - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ref_ff <= LCEP_REF_RST;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_REF) begin
            if (wb_sel_i[0]) ref_ff[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ref_ff[15:8] <= wb_dat_i[15:8];
        end else if (kp_ref_evt && kp_ref_ok) begin
            ref_ff <= kp_ref_up ? ref_ff + 16'h0001 : ref_ff - 16'h0001;
        end
    end

    // refused edits only mark a status bit, nothing else moves
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            refused_ff <= 1'b0;
        end else if ((kp_par_evt && !kp_par_ok)
                     || (kp_ref_evt && !kp_ref_ok)) begin
            refused_ff <= 1'b1;
        end else if (wr_ok && wb_adr_i == LCEP_OFS_STATUS && wb_sel_i[0]
                     && wb_dat_i[1]) begin
            refused_ff <= 1'b0;
        end
    end

    assign param_value = param_ff;
    assign ref_value   = ref_ff;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            if (wb_adr_i == LCEP_OFS_LINK) begin
                wb_dat_o <= {14'h0000, proto_ff, 3'h0, stop_ff, 2'h0,
                             par_ff, 3'h0, dlen_ff, 1'b0, baud_ff};
            end else if (wb_adr_i == LCEP_OFS_TIMING) begin
                wb_dat_o <= {17'h00000, respiv_ff, 2'h0, noresp_ff};
            end else if (wb_adr_i == LCEP_OFS_MODE) begin
                wb_dat_o <= {30'h00000000, busmode_ff};
            end else if (wb_adr_i == LCEP_OFS_PROTECT) begin
                wb_dat_o <= {30'h00000000, prot_ff};
            end else if (wb_adr_i == LCEP_OFS_PARAM) begin
                wb_dat_o <= {16'h0000, param_ff};
            end else if (wb_adr_i == LCEP_OFS_REF) begin
                wb_dat_o <= {16'h0000, ref_ff};
            end else if (wb_adr_i == LCEP_OFS_STATUS) begin
                wb_dat_o <= {28'h0000000, kp_ref_ok, kp_par_ok,
                             refused_ff, noresp_err_ff};
            end else if (wb_adr_i == LCEP_OFS_SILENCE) begin
                wb_dat_o <= {31'h00000000, link_reply_ok};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule : lcep_bank
`default_nettype wire

// File: verif/lcep_host_model.sv
// lcep_host_model: far-side host on the serial link, as link events.
// assumes the bank's clock and reset; go asks for one request.
`timescale 1ns/100ps
`default_nettype none
module lcep_host_model (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // command and link events
    input  wire logic go,
    output logic      req_done,
    output logic      rx_act
);
    // ----------
    // request framing
    // ----------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_done <= 1'b0;
            rx_act   <= 1'b0;
        end else begin
            req_done <= go;
            rx_act   <= go;
        end
    end
endmodule : lcep_host_model
`default_nettype wire

// File: verif/lcep_bank_assertions.sv
// lcep_bank_chk: port-level checks of the bank, bound to lcep_bank.
// assumes one clock and the active-low reset at the ports.
`timescale 1ns/100ps
`default_nettype none
module lcep_bank_chk
    import lcep_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o,
    // keypad and outputs
    input  wire logic        kp_param_up,
    input  wire logic        kp_param_dn,
    input  wire logic        kp_ref_up,
    input  wire logic        kp_ref_dn,
    input  wire logic [31:0] link_baud_bps,
    input  wire logic [3:0]  link_char_bits,
    input  wire logic        link_parity_en,
    input  wire logic [1:0]  link_stop_bits,
    input  wire logic        link_proto_rtu,
    input  wire logic [15:0] param_value,
    input  wire logic [15:0] ref_value
);
    // ----------
    // checks
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence par_wr;
        bus_req ##0 (wb_we_i && wb_adr_i == LCEP_OFS_PARAM && &wb_sel_i);
    endsequence
    bus_answer_a: assert property (bus_req |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack longer than one cycle");
    baud_legal_a: assert property (link_baud_bps == 19200 ||
        link_baud_bps == 38400) else $error("illegal rate");
    char_len_a: assert property (link_char_bits inside {4'h7, 4'h8})
        else $error("illegal length");
    rtu_stop_a: assert property (link_proto_rtu && link_parity_en |->
        link_stop_bits == 2'h1) else $error("stop bits wrong");
    param_wr_a: assert property (par_wr |=>
        param_value == 16'($past(wb_dat_i))) else $error("write lost");
    param_hold_a: assert property (!(wb_cyc_i && wb_stb_i) &&
        !kp_param_up && !kp_param_dn |=> $stable(param_value))
        else $error("value moved");
    ref_hold_a: assert property (!(wb_cyc_i && wb_stb_i) &&
        !kp_ref_up && !kp_ref_dn |=> $stable(ref_value))
        else $error("reference moved");
endmodule : lcep_bank_chk
bind lcep_bank lcep_bank_chk lcep_bank_chk_inst (.mclk(mclk),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .kp_param_up(kp_param_up), .kp_param_dn(kp_param_dn),
    .kp_ref_up(kp_ref_up), .kp_ref_dn(kp_ref_dn),
    .link_baud_bps(link_baud_bps), .link_char_bits(link_char_bits),
    .link_parity_en(link_parity_en), .link_stop_bits(link_stop_bits),
    .link_proto_rtu(link_proto_rtu), .param_value(param_value),
    .ref_value(ref_value));
`default_nettype wire

// File: verif/lcep_bank_tb.sv
// lcep_bank_tb: register and keypad sequences against the bank.
// assumes the bank answers a bus request one cycle after it is taken.
`timescale 1ns/100ps
`default_nettype none
module lcep_bank_tb
    import lcep_pkg::*;
;
    // ----------
    // stimulus and checks
    // ----------
    logic        mclk, resetn, cyc, stb, we, ack, werr, go, rq, rx, pen, pm;
    logic        rok, pen_o, odd, rtu, ff, rf, berr, nerr;
    logic [7:0]  adr;
    logic [3:0]  sel, cbits;
    logic [5:0]  kpv;
    logic [1:0]  stopb;
    logic [15:0] pv, rv, pval, rval;
    logic [31:0] wd, dato, rd, baud;
    int          err_count, n_compared, cyc_cnt;
    lcep_bank lcep_bank_inst (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(werr),
        .kp_param_up(kpv[0]), .kp_param_dn(kpv[1]), .kp_ref_up(kpv[2]),
        .kp_ref_dn(kpv[3]), .kp_combo_lock(kpv[4]),
        .kp_combo_unlock(kpv[5]), .keypad_edit_permit_en(pen),
        .keypad_edit_permit(pm), .link_req_done(rq), .link_rx_activity(rx),
        .link_reply_ok(rok), .link_baud_bps(baud), .link_char_bits(cbits),
        .link_parity_en(pen_o), .link_parity_odd(odd),
        .link_stop_bits(stopb), .link_proto_rtu(rtu), .link_noresp_err(nerr),
        .freq_from_fieldbus(ff), .run_from_fieldbus(rf),
        .param_value(pval), .ref_value(rval));
    lcep_host_model lcep_host_model_inst (.mclk(mclk), .resetn(resetn),
        .go(go), .req_done(rq), .rx_act(rx));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hf};
        do @(posedge mclk); while (ack !== 1'b1 && werr !== 1'b1);
        rd = dato;
        berr = werr;
        {cyc, stb, we} <= 3'h0;
        @(posedge mclk);
    endtask : bus
    task kp(input logic [5:0] k);
        @(posedge mclk) kpv <= k;
        @(posedge mclk) kpv <= 6'h0;
        @(posedge mclk);
    endtask : kp
    task final_report;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    // bounded run: a stuck handshake ends here
    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        {resetn, cyc, stb, we, go, pen, pm, kpv, adr, sel, wd} = 0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(baud, 19200);
        chk({cbits, stopb, rtu}, {4'h8, 2'h2, 1'b1});
        bus(1'b1, LCEP_OFS_LINK, 32'h0002_0114);
        chk({baud, cbits, pen_o, stopb, rtu}, {32'd38400, 4'h7, 4'hc});
        bus(1'b1, LCEP_OFS_LINK, 32'h0002_1115);
        chk({baud, stopb}, {32'd38400, 2'h1});
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, LCEP_OFS_LINK, 32'h3 | (p << 8));
            chk({pen_o, odd, rtu}, {p == 1 || p == 2, p == 2, 1'b1});
            chk(stopb, p == 0 ? 2 : 1);
            bus(1'b1, LCEP_OFS_MODE, p);
            chk({rf, ff}, p);
        end
        $display("link and mode test done");
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, LCEP_OFS_PROTECT, p);
            {pv, rv} = {pval, rval};
            kp(6'h01);
            kp(6'h04);
            chk(pval, p[0] ? pv : pv + 16'h1);
            chk(rval, p[1] ? rv : rv + 16'h1);
        end
        bus(1'b0, LCEP_OFS_STATUS, 0);
        chk({rd[3:0], nerr}, 5'h04);
        bus(1'b1, LCEP_OFS_PARAM, 32'h1234);
        chk(pval, 16'h1234);
        bus(1'b1, LCEP_OFS_PROTECT, 0);
        @(posedge mclk) {pen, pm} <= 2'b10;
        kp(6'h02);
        chk(pval, 16'h1234);
        @(posedge mclk) pm <= 1'b1;
        kp(6'h01);
        chk(pval, 16'h1235);
        kp(6'h10);
        bus(1'b0, LCEP_OFS_PROTECT, 0);
        chk(rd[1:0], 2'h1);
        kp(6'h20);
        bus(1'b0, LCEP_OFS_PROTECT, 0);
        chk(rd[1:0], 2'h0);
        $display("protection test done");
        bus(1'b0, 8'h20, 0);
        chk({berr, rok}, 2'h2);
        bus(1'b1, LCEP_OFS_TIMING, 32'h3d);
        bus(1'b0, LCEP_OFS_TIMING, 0);
        chk(rd, 32'h0);
        @(posedge mclk) go <= 1'b1;
        @(posedge mclk) go <= 1'b0;
        @(negedge mclk) chk(rok, 1'b0);
        @(negedge mclk) chk(rok, 1'b1);
        $display("bus and reply test done");
        final_report();
    end
endmodule : lcep_bank_tb
`default_nettype wire
